// *** rtl/ueprx_consts.svh ***
// constants for the endpoint receive-arm / endpoint-one control block
// assumes: included by bare name from the design files and the bench top
`ifndef UEPRX_CONSTS_SVH
`define UEPRX_CONSTS_SVH
// printed offsets are register indexes; byte address is four times the index
`define UEPRX_IDX_RXC0   32'h5000_184e
`define UEPRX_IDX_EPC1   32'h5000_1850
`define UEPRX_IDX_TXD1   32'h5000_1852
`define UEPRX_ADR_MSB    13
`define UEPRX_ADR_LSB    2
`define UEPRX_IDX_W      12
`define UEPRX_RXC0_RST   16'h0000
`define UEPRX_EPC1_RST   16'h0000
`define UEPRX_RXC0_ARM   0
`define UEPRX_RXC0_IGNO  1
`define UEPRX_RXC0_IGNS  2
`define UEPRX_RXC0_FLSH  3
`define UEPRX_EPC1_STL   7
`define UEPRX_EPC1_ISO   5
`define UEPRX_EPC1_EN    4
`define UEPRX_EPC1_EPM   3
`define UEPRX_EPC1_EPL   0
`define UEPRX_BYTE_MSB   7
`define UEPRX_FIFO_DEPTH 7'h40
`define UEPRX_PTR_W      7
`define UEPRX_AW         6
`define UEPRX_PID_DATA0  8'hc3
`define UEPRX_PID_DATA1  8'h4b
`define UEPRX_CRC_INIT   16'hffff
`define UEPRX_CRC_POLY   16'ha001
`endif

// *** rtl/ueprx_pkg.sv ***
// types shared by the endpoint control block and its helpers
// assumes: single clock pclk, all link-side inputs come from logic on pclk
`default_nettype none
package ueprx_pkg;
  typedef enum logic [1:0] {UEPRX_TOK_OUT, UEPRX_TOK_IN, UEPRX_TOK_SETUP} ueprx_pid_e;
  typedef enum logic [1:0] {UEPRX_HS_ACK, UEPRX_HS_NAK, UEPRX_HS_STALL} ueprx_hs_e;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ueprx_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ueprx_apb_rsp_s;
  typedef struct packed {
    logic       valid;
    ueprx_pid_e pid;
    logic [6:0] addr;
    logic [3:0] ep;
  } ueprx_tok_s;
  typedef struct packed {
    logic valid;
    logic good;
  } ueprx_rxd_s;
  typedef struct packed {
    logic      valid;
    ueprx_hs_e code;
  } ueprx_hs_s;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } ueprx_beat_s;
endpackage
`default_nettype wire

// *** rtl/ueprx_mem.sv ***
// byte store of the endpoint-one transmit fifo, read data registered
// assumes: one write and one read address per cycle, same clock
`default_nettype none
`include "ueprx_consts.svh"
module ueprx_mem (
  input  wire logic                   pclk,
  input  wire logic                   we,
  input  wire logic [`UEPRX_AW-1:0]   waddr,
  input  wire logic [7:0]             wdata,
  input  wire logic [`UEPRX_AW-1:0]   raddr,
  output logic      [7:0]             rdata_ff
);
  logic [7:0] mem_ff [0:(1<<`UEPRX_AW)-1];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    rdata_ff <= mem_ff[raddr];
  end
endmodule
`default_nettype wire

// *** rtl/ueprx_buf2.sv ***
// two-entry buffer with valid/ready on both sides
// assumes: the receiver may hold out_ready low for any time; nothing is lost
`default_nettype none
module ueprx_buf2
  import ueprx_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire ueprx_pkg::ueprx_beat_s in_beat,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output ueprx_pkg::ueprx_beat_s     out_beat
);
  ueprx_beat_s ent_ff [0:1];
  logic        wp_ff;
  logic        rp_ff;
  logic [1:0]  cnt_ff;
  logic        push;
  logic        pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_beat  = ent_ff[rp_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ent_ff[0] <= '0;
      ent_ff[1] <= '0;
    end else if (push) begin
      ent_ff[wp_ff] <= in_beat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      wp_ff  <= wp_ff ^ push;
      rp_ff  <= rp_ff ^ pop;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// *** rtl/ueprx_ctrl.sv ***
// control endpoint receive arm and endpoint-one configuration, apb slave
// assumes: token and data-end pulses come from a serial engine on pclk;
// the function address and fifo enables come from neighbouring registers
// Summary of operation
// - the control endpoint receive arm clears after each data packet received for an OUT and after an OUT is stalled.
// - a valid SETUP right after another SETUP with no other control-endpoint token between is dropped but acknowledged.
// - a SETUP that cannot be taken for any other reason gets no handshake.
// - with halt set, IN is stalled while the transmit fifo is enabled and OUT while the receive fifo is.
// - the halt bit never makes a SETUP token stall.
// - an isochronous endpoint never answers NAK when it is not ready.
// - when enabled, tokens match on both the endpoint number and the seven-bit device address.
// - when disabled, endpoint one ignores all tokens and answers nothing.
// - the endpoint number is a four-bit read/write field reset to zero.
// - firmware writes payload only; the block adds packet id and crc16 to the outgoing stream.
// - the transmit fifo port is write only, readable too in test mode.
//
// The APB register port was left to the implementer.
`default_nettype none
`include "ueprx_consts.svh"
module ueprx_ctrl
  import ueprx_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire ueprx_pkg::ueprx_apb_req_s apb_req,
  output ueprx_pkg::ueprx_apb_rsp_s     apb_rsp,
  input  wire logic                     test_mode,
  input  wire logic [6:0]               function_address_reg,
  input  wire ueprx_pkg::ueprx_tok_s    tok,
  input  wire ueprx_pkg::ueprx_rxd_s    rx_done,
  input  wire logic                     ep0_stall,
  input  wire logic                     ep0_fifo_busy,
  input  wire logic                     ep1_tx_fifo_en,
  input  wire logic                     ep1_rx_fifo_en,
  input  wire logic                     ep1_rx_full,
  input  wire logic                     ep1_host_ack,
  output ueprx_pkg::ueprx_hs_s          hs,
  output logic                          ep0_setup_take,
  output logic                          ep0_setup_drop,
  output logic                          ep0_flush,
  output logic                          tx_valid,
  input  wire logic                     tx_ready,
  output ueprx_pkg::ueprx_beat_s        tx_beat
);
  typedef enum logic [2:0] {CUR_NONE, CUR_OUT0, CUR_SETUP0, CUR_OUT1, CUR_SETUP1} ueprx_cur_e;
  typedef enum logic [2:0] {TX_IDLE, TX_PID, TX_DATA, TX_CRC_LO, TX_CRC_HI} ueprx_tx_e;
  localparam logic [15:0] RXC0_RST = `UEPRX_RXC0_RST;
  localparam logic [15:0] EPC1_RST = `UEPRX_EPC1_RST;

  function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] idx);
    reg_hit = (addr[`UEPRX_ADR_MSB:`UEPRX_ADR_LSB] == idx[`UEPRX_IDX_W-1:0]);
  endfunction

  // reflected crc16 over one byte, lsb first as it goes on the wire
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `UEPRX_CRC_POLY) : (c >> 1);
    end
    crc_byte = c;
  endfunction

  logic        rx_arm_ff;
  logic        ign_out_ff;
  logic        ign_setup_ff;
  logic        flush_ff;
  logic        stall_ff;
  logic        iso_ff;
  logic        ep_en_ff;
  logic [3:0]  endpoint_number_field_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  ueprx_hs_s   hs_ff;
  ueprx_hs_s   nxt_hs;
  ueprx_cur_e  cur_ff;
  ueprx_cur_e  nxt_cur;
  logic        setup_seen_ff;
  logic        setup_rep_ff;
  logic        take_ff;
  logic        drop_ff;
  ueprx_tx_e   tx_st_ff;
  logic [`UEPRX_PTR_W-1:0] wr_ptr_ff;
  logic [`UEPRX_PTR_W-1:0] rd_ptr_ff;
  logic [`UEPRX_PTR_W-1:0] left_ff;
  logic [`UEPRX_PTR_W-1:0] fifo_cnt;
  logic        rd_wait_ff;
  logic [15:0] crc_ff;
  logic        toggle_ff;
  logic [7:0]  mem_rdata;
  logic        acc;
  logic        setup_ph;
  logic        wr_rxc0;
  logic        wr_epc1;
  logic        wr_txd1;
  logic        fifo_full;
  logic        push_fifo;
  logic        hit0;
  logic        hit1;
  logic        clr_arm;
  logic        set_take;
  logic        set_drop;
  logic        start_tx;
  ueprx_beat_s buf_beat;
  logic        buf_valid;
  logic        buf_ready;
  logic        buf_push;

  assign acc       = apb_req.psel & apb_req.penable;
  assign setup_ph  = apb_req.psel & ~apb_req.penable;
  assign wr_rxc0   = acc & apb_req.pwrite & reg_hit(apb_req.paddr, `UEPRX_IDX_RXC0);
  assign wr_epc1   = acc & apb_req.pwrite & reg_hit(apb_req.paddr, `UEPRX_IDX_EPC1);
  assign wr_txd1   = acc & apb_req.pwrite & reg_hit(apb_req.paddr, `UEPRX_IDX_TXD1);
  assign fifo_cnt  = wr_ptr_ff - rd_ptr_ff;
  assign fifo_full = (fifo_cnt == `UEPRX_FIFO_DEPTH);
  assign push_fifo = wr_txd1 & ~fifo_full;

  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.prdata  = prdata_ff;
  assign apb_rsp.pslverr = pslverr_ff & acc;
  assign hs              = hs_ff;
  assign ep0_setup_take  = take_ff;
  assign ep0_setup_drop  = drop_ff;
  assign ep0_flush       = flush_ff;

  // read data captured in the setup phase so prdata is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
      if (reg_hit(apb_req.paddr, `UEPRX_IDX_RXC0)) begin
        prdata_ff[`UEPRX_RXC0_ARM]  <= rx_arm_ff;
        prdata_ff[`UEPRX_RXC0_IGNO] <= ign_out_ff;
        prdata_ff[`UEPRX_RXC0_IGNS] <= ign_setup_ff;
      end else if (reg_hit(apb_req.paddr, `UEPRX_IDX_EPC1)) begin
        prdata_ff[`UEPRX_EPC1_STL] <= stall_ff;
        prdata_ff[`UEPRX_EPC1_ISO] <= iso_ff;
        prdata_ff[`UEPRX_EPC1_EN]  <= ep_en_ff;
        prdata_ff[`UEPRX_EPC1_EPM:`UEPRX_EPC1_EPL] <= endpoint_number_field_ff;
      end else if (reg_hit(apb_req.paddr, `UEPRX_IDX_TXD1)) begin
        if (test_mode) begin
          prdata_ff[`UEPRX_BYTE_MSB:0] <= mem_rdata;
        end
      end else begin
        pslverr_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_arm_ff    <= RXC0_RST[`UEPRX_RXC0_ARM];
      ign_out_ff   <= RXC0_RST[`UEPRX_RXC0_IGNO];
      ign_setup_ff <= RXC0_RST[`UEPRX_RXC0_IGNS];
    end else begin
      // auto clear arm; a firmware arm in the same cycle wins
      if (clr_arm) begin
        rx_arm_ff <= 1'b0;
      end
      if (wr_rxc0) begin
        if (apb_req.pwdata[`UEPRX_RXC0_ARM]) begin
          rx_arm_ff <= 1'b1;
        end else if (!clr_arm) begin
          rx_arm_ff <= 1'b0;
        end
        ign_out_ff   <= apb_req.pwdata[`UEPRX_RXC0_IGNO];
        ign_setup_ff <= apb_req.pwdata[`UEPRX_RXC0_IGNS];
      end
    end
  end

  // flush reads back zero: it is a one-cycle pulse to the fifo logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_ff <= RXC0_RST[`UEPRX_RXC0_FLSH];
    end else begin
      flush_ff <= wr_rxc0 & apb_req.pwdata[`UEPRX_RXC0_FLSH];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_ff <= EPC1_RST[`UEPRX_EPC1_STL];
      iso_ff   <= EPC1_RST[`UEPRX_EPC1_ISO];
      ep_en_ff <= EPC1_RST[`UEPRX_EPC1_EN];
      endpoint_number_field_ff <= EPC1_RST[`UEPRX_EPC1_EPM:`UEPRX_EPC1_EPL];
    end else if (wr_epc1) begin
      stall_ff <= apb_req.pwdata[`UEPRX_EPC1_STL];
      iso_ff   <= apb_req.pwdata[`UEPRX_EPC1_ISO];
      ep_en_ff <= apb_req.pwdata[`UEPRX_EPC1_EN];
      endpoint_number_field_ff <= apb_req.pwdata[`UEPRX_EPC1_EPM:`UEPRX_EPC1_EPL];
    end
  end

  assign hit0 = (tok.addr == function_address_reg) && (tok.ep == 4'h0);
  assign hit1 = ep_en_ff && (tok.addr == function_address_reg) &&
                (tok.ep == endpoint_number_field_ff);

  always_comb begin
    nxt_hs   = '0;
    nxt_hs.code = UEPRX_HS_ACK;
    nxt_cur  = cur_ff;
    clr_arm  = 1'b0;
    set_take = 1'b0;
    set_drop = 1'b0;
    start_tx = 1'b0;
    if (tok.valid) begin
      nxt_cur = CUR_NONE;
      if (hit0) begin
        case (tok.pid)
          UEPRX_TOK_SETUP: begin
            if (!ign_setup_ff) begin
              nxt_cur = CUR_SETUP0;
            end
          end
          UEPRX_TOK_OUT: begin
            if (!ign_out_ff) begin
              if (ep0_stall) begin
                nxt_hs.valid = 1'b1;
                nxt_hs.code  = UEPRX_HS_STALL;
                clr_arm      = 1'b1;
              end else if (!rx_arm_ff) begin
                nxt_hs.valid = 1'b1;
                nxt_hs.code  = UEPRX_HS_NAK;
              end else begin
                nxt_cur = CUR_OUT0;
              end
            end
          end
          default: begin
          end
        endcase
      end else if (hit1) begin
        case (tok.pid)
          UEPRX_TOK_SETUP: begin
            nxt_cur = CUR_SETUP1;
          end
          UEPRX_TOK_OUT: begin
            if (stall_ff && ep1_rx_fifo_en) begin
              nxt_hs.valid = 1'b1;
              nxt_hs.code  = UEPRX_HS_STALL;
            end else if (ep1_rx_full) begin
              nxt_hs.valid = ~iso_ff;
              nxt_hs.code  = UEPRX_HS_NAK;
            end else begin
              nxt_cur = CUR_OUT1;
            end
          end
          UEPRX_TOK_IN: begin
            if (stall_ff && ep1_tx_fifo_en) begin
              nxt_hs.valid = 1'b1;
              nxt_hs.code  = UEPRX_HS_STALL;
            end else if (fifo_cnt == '0 || tx_st_ff != TX_IDLE) begin
              nxt_hs.valid = ~iso_ff;
              nxt_hs.code  = UEPRX_HS_NAK;
            end else begin
              start_tx = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (rx_done.valid) begin
      nxt_cur = CUR_NONE;
      case (cur_ff)
        CUR_OUT0: begin
          clr_arm      = 1'b1;
          nxt_hs.valid = rx_done.good;
        end
        CUR_SETUP0: begin
          if (rx_done.good && setup_rep_ff) begin
            nxt_hs.valid = 1'b1;
            set_drop     = 1'b1;
          end else if (rx_done.good && !ep0_fifo_busy) begin
            nxt_hs.valid = 1'b1;
            set_take     = 1'b1;
          end
        end
        CUR_OUT1: begin
          nxt_hs.valid = rx_done.good & ~iso_ff;
        end
        CUR_SETUP1: begin
          nxt_hs.valid = rx_done.good;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_ff   <= '0;
      cur_ff  <= CUR_NONE;
      take_ff <= 1'b0;
      drop_ff <= 1'b0;
    end else begin
      hs_ff   <= nxt_hs;
      cur_ff  <= nxt_cur;
      take_ff <= set_take;
      drop_ff <= set_drop;
    end
  end

  // a setup marks the control endpoint until any other token reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_seen_ff <= 1'b0;
      setup_rep_ff  <= 1'b0;
    end else if (tok.valid && hit0) begin
      setup_seen_ff <= (tok.pid == UEPRX_TOK_SETUP);
      setup_rep_ff  <= setup_seen_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= '0;
    end else if (push_fifo) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  // payload from firmware, pid and crc added here
  always_comb begin
    buf_beat = '0;
    case (tx_st_ff)
      TX_PID: begin
        buf_beat.data = toggle_ff ? `UEPRX_PID_DATA1 : `UEPRX_PID_DATA0;
      end
      TX_DATA: begin
        buf_beat.data = mem_rdata;
      end
      TX_CRC_LO: begin
        buf_beat.data = ~crc_ff[7:0];
      end
      TX_CRC_HI: begin
        buf_beat.data = ~crc_ff[15:8];
        buf_beat.last = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // the store answers one cycle after the pointer moves, hence the wait bubble
  assign buf_valid = (tx_st_ff != TX_IDLE) && !(tx_st_ff == TX_DATA && rd_wait_ff);
  assign buf_push  = buf_valid & buf_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff   <= TX_IDLE;
      rd_ptr_ff  <= '0;
      left_ff    <= '0;
      rd_wait_ff <= 1'b0;
      crc_ff     <= `UEPRX_CRC_INIT;
    end else begin
      rd_wait_ff <= 1'b0;
      case (tx_st_ff)
        TX_IDLE: begin
          if (start_tx) begin
            tx_st_ff <= TX_PID;
            left_ff  <= fifo_cnt;
            crc_ff   <= `UEPRX_CRC_INIT;
          end
        end
        TX_PID: begin
          if (buf_push) begin
            tx_st_ff <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (buf_push) begin
            rd_ptr_ff  <= rd_ptr_ff + 1'b1;
            left_ff    <= left_ff - 1'b1;
            rd_wait_ff <= 1'b1;
            crc_ff     <= crc_byte(crc_ff, mem_rdata);
            if (left_ff == 7'h01) begin
              tx_st_ff <= TX_CRC_LO;
            end
          end
        end
        TX_CRC_LO: begin
          if (buf_push) begin
            tx_st_ff <= TX_CRC_HI;
          end
        end
        TX_CRC_HI: begin
          if (buf_push) begin
            tx_st_ff <= TX_IDLE;
          end
        end
        default: begin
          tx_st_ff <= TX_IDLE;
        end
      endcase
    end
  end

  // isochronous packets always go out as data0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_ff <= 1'b0;
    end else if (iso_ff) begin
      toggle_ff <= 1'b0;
    end else if (ep1_host_ack) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  ueprx_mem u_mem (
    .pclk     (pclk),
    .we       (push_fifo),
    .waddr    (wr_ptr_ff[`UEPRX_AW-1:0]),
    .wdata    (apb_req.pwdata[`UEPRX_BYTE_MSB:0]),
    .raddr    (rd_ptr_ff[`UEPRX_AW-1:0]),
    .rdata_ff (mem_rdata)
  );

  ueprx_buf2 u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (buf_valid),
    .in_ready  (buf_ready),
    .in_beat   (buf_beat),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_beat  (tx_beat)
  );
endmodule
`default_nettype wire

// *** bench/ueprx_checker.sv ***
// assertions on the endpoint control block ports
// assumes: bound into ueprx_ctrl, one clock pclk
`default_nettype none
module ueprx_checker (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire ueprx_pkg::ueprx_apb_req_s apb_req,
  input wire ueprx_pkg::ueprx_apb_rsp_s apb_rsp,
  input wire logic                      test_mode,
  input wire logic [6:0]                function_address_reg,
  input wire ueprx_pkg::ueprx_tok_s     tok,
  input wire logic                      ep1_tx_fifo_en,
  input wire ueprx_pkg::ueprx_hs_s      hs,
  input wire logic                      tx_valid,
  input wire logic                      tx_ready,
  input wire ueprx_pkg::ueprx_beat_s    tx_beat
);
  timeunit 1ns;
  timeprecision 1ps;
  import ueprx_pkg::*;
  logic [7:0]  cfg_ff;
  logic [11:0] idx;
  logic        hit;
  assign idx = apb_req.paddr[13:2];
  // ep0 takes priority when the configured number is zero
  assign hit = tok.valid && cfg_ff[4] && tok.ep == cfg_ff[3:0] && cfg_ff[3:0] != 4'h0
               && tok.addr == function_address_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= 8'h00;
    end else if (apb_req.psel && apb_req.penable && apb_req.pwrite && idx == 12'h850) begin
      cfg_ff <= apb_req.pwdata[7:0] & 8'hbf;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_setup(logic [11:0] a);
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && idx == a;
  endsequence
  chk_cfg_readback: assert property (rd_setup(12'h850)
    |=> apb_rsp.prdata == {24'h0, cfg_ff}) else $error("ep1 config readback wrong");
  chk_rxc_reserved: assert property (rd_setup(12'h84e) |=> apb_rsp.prdata[31:3] == '0)
    else $error("rx control upper bits not zero");
  chk_txport_wo: assert property (rd_setup(12'h852) ##0 !test_mode
    |=> apb_rsp.prdata == '0) else $error("tx port readable outside test mode");
  chk_unmapped_err: assert property (apb_req.psel && apb_req.penable
    && !(idx inside {12'h84e, 12'h850, 12'h852}) |-> apb_rsp.pslverr && apb_rsp.pready)
    else $error("unmapped access without error");
  chk_halt_stall: assert property (hit && cfg_ff[7] && tok.pid == UEPRX_TOK_IN
    && ep1_tx_fifo_en |=> hs.valid && hs.code == UEPRX_HS_STALL) else $error("halted IN not stalled");
  chk_setup_nostall: assert property (tok.valid && tok.pid == UEPRX_TOK_SETUP
    |=> !(hs.valid && hs.code == UEPRX_HS_STALL)) else $error("SETUP stalled");
  chk_iso_no_nak: assert property (hit && cfg_ff[5]
    |=> !(hs.valid && hs.code == UEPRX_HS_NAK)) else $error("isochronous endpoint sent NAK");
  chk_off_silent: assert property (tok.valid && !cfg_ff[4] && cfg_ff[3:0] != 4'h0
    && tok.ep == cfg_ff[3:0] |=> !hs.valid) else $error("disabled endpoint answered");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat))
    else $error("tx beat changed while stalled");
  cov_stall: cover property (hs.valid && hs.code == UEPRX_HS_STALL);
  cov_tx_wait: cover property (tx_valid && !tx_ready);
  cov_tx_end: cover property (tx_valid && tx_ready && tx_beat.last);
endmodule
bind ueprx_ctrl ueprx_checker ueprx_checker_inst (.*);
`default_nettype wire

// *** bench/ueprx_host_model.sv ***
// usb host model: tokens, data-end pulses, drains the tx stream with stalls
// assumes: tasks called from the bench, all on pclk
`default_nettype none
module ueprx_host_model (
  input  wire logic              pclk,
  output ueprx_pkg::ueprx_tok_s  tok,
  output ueprx_pkg::ueprx_rxd_s  rx_done,
  output logic                   tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import ueprx_pkg::*;
  initial begin
    tok = '0;
    rx_done = '0;
  end
  // random stalls force the buffer to hold beats
  always @(posedge pclk) tx_ready <= 1'($urandom_range(0, 1));
  task automatic send(input ueprx_pid_e p, input logic [6:0] a, input logic [3:0] e,
                      input int gap, input logic good);
    @(posedge pclk);
    tok <= '{1'b1, p, a, e};
    @(posedge pclk);
    // idle fields flip so stale values never look live
    tok <= '{1'b0, p, ~a, ~e};
    if (gap > 0) begin
      repeat (gap) @(posedge pclk);
      rx_done <= '{1'b1, good};
      @(posedge pclk);
      rx_done <= '{1'b0, ~good};
    end
    repeat (3) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the endpoint control block
// assumes: host model on the link side, firmware played by apb tasks
`default_nettype none
`include "ueprx_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ueprx_pkg::*;
  localparam logic [31:0] RXC = 32'h0000_6138, CFG = 32'h0000_6140, TXP = 32'h0000_6148;
  logic pclk = 1'b0, presetn = 1'b0, test_mode = 1'b0, rx_full = 1'b0, fen = 1'b1, busy = 1'b0;
  ueprx_apb_req_s req = '0;
  ueprx_apb_rsp_s rsp;
  ueprx_tok_s tok;
  ueprx_rxd_s rxd;
  ueprx_hs_s hs;
  ueprx_beat_s beat;
  logic tx_valid, tx_ready, take, drop;
  int miscompares = 0, checks_done = 0, drops = 0, takes = 0;
  logic [31:0] rdq[$];
  ueprx_hs_e hsq[$];
  logic [8:0] bq[$];
  logic [15:0] crc;
  logic [31:0] d;
  always #2.5 pclk = ~pclk;
  ueprx_ctrl ueprx_ctrl_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .test_mode(test_mode), .function_address_reg(7'h2a), .tok(tok), .rx_done(rxd),
    .ep0_stall(1'b0), .ep0_fifo_busy(busy), .ep1_tx_fifo_en(fen), .ep1_rx_fifo_en(fen),
    .ep1_rx_full(rx_full), .ep1_host_ack(1'b0), .hs(hs), .ep0_setup_take(take),
    .ep0_setup_drop(drop), .ep0_flush(), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(beat));
  ueprx_host_model ueprx_host_model_inst (.pclk(pclk), .tok(tok), .rx_done(rxd),
    .tx_ready(tx_ready));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n == 50) cmp("pready", 1, 0);
    req <= '{1'b0, 1'b0, ~wr, ~a, ~wd};
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic send(input ueprx_pid_e p, input logic [3:0] e, input int gap);
    ueprx_host_model_inst.send(p, 7'h2a, e, gap, 1'b1);
  endtask
  // results are paired with the oldest note as they appear
  always @(posedge pclk) begin
    if (req.psel && req.penable && !req.pwrite) begin
      if (rdq.size() == 0) cmp("read unexpected", 0, 1); else cmp("read", rdq.pop_front(), rsp.prdata);
    end
    if (hs.valid === 1'b1) begin
      if (hsq.size() == 0) cmp("hs unexpected", 0, 1); else cmp("hs", hsq.pop_front(), hs.code);
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (bq.size() == 0) cmp("beat unexpected", 0, 1); else cmp("beat", bq.pop_front(), beat);
    end
    drops += int'(drop === 1'b1);
    takes += int'(take === 1'b1);
  end
  initial begin
    repeat (20000) @(posedge pclk);
    cmp("timeout", 0, 1);
    finish_test();
  end
  initial begin
    int n;
    void'($urandom(32'hf9e5_b848));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(RXC, 32'h0000_0000);
    rd(CFG, 32'h0000_0000);
    apb(1'b1, CFG, 32'hffff_ff53);
    rd(CFG, 32'h0000_0013);
    apb(1'b1, 32'h0000_6150, 32'hffff_ffff);
    rd(32'h0000_6150, 32'h0000_0000);
    hsq.push_back(UEPRX_HS_ACK);
    send(UEPRX_TOK_OUT, 4'h3, 3);
    ueprx_host_model_inst.send(UEPRX_TOK_OUT, 7'h2b, 4'h3, 3, 1'b1);
    hsq.push_back(UEPRX_HS_NAK);
    send(UEPRX_TOK_IN, 4'h3, 0);
    apb(1'b1, CFG, 32'h0000_0003);
    send(UEPRX_TOK_OUT, 4'h3, 3);
    apb(1'b1, CFG, 32'h0000_0033);
    send(UEPRX_TOK_IN, 4'h3, 0);
    rx_full <= 1'b1;
    send(UEPRX_TOK_OUT, 4'h3, 0);
    rx_full <= 1'b0;
    apb(1'b1, CFG, 32'h0000_0093);
    hsq.push_back(UEPRX_HS_STALL);
    send(UEPRX_TOK_IN, 4'h3, 0);
    hsq.push_back(UEPRX_HS_STALL);
    send(UEPRX_TOK_OUT, 4'h3, 0);
    hsq.push_back(UEPRX_HS_ACK);
    send(UEPRX_TOK_SETUP, 4'h3, 3);
    apb(1'b1, RXC, 32'h0000_0001);
    hsq.push_back(UEPRX_HS_ACK);
    send(UEPRX_TOK_OUT, 4'h0, 3);
    rd(RXC, 32'h0000_0000);
    hsq.push_back(UEPRX_HS_ACK);
    send(UEPRX_TOK_SETUP, 4'h0, 3);
    hsq.push_back(UEPRX_HS_ACK);
    send(UEPRX_TOK_SETUP, 4'h0, 3);
    hsq.push_back(UEPRX_HS_NAK);
    send(UEPRX_TOK_OUT, 4'h0, 0);
    busy <= 1'b1;
    send(UEPRX_TOK_SETUP, 4'h0, 3);
    busy <= 1'b0;
    apb(1'b1, RXC, 32'h0000_0004);
    send(UEPRX_TOK_SETUP, 4'h0, 3);
    apb(1'b1, CFG, 32'h0000_0013);
    bq.push_back({`UEPRX_PID_DATA0, 1'b0});
    crc = `UEPRX_CRC_INIT;
    for (int i = 0; i < 1 + $urandom_range(0, 3); i++) begin
      d = $urandom;
      apb(1'b1, TXP, d);
      bq.push_back({d[7:0], 1'b0});
      for (int k = 0; k < 8; k++) crc = (crc[0] ^ d[k]) ? (crc >> 1) ^ `UEPRX_CRC_POLY : crc >> 1;
    end
    crc = ~crc;
    bq.push_back({crc[7:0], 1'b0});
    bq.push_back({crc[15:8], 1'b1});
    rd(TXP, 32'h0000_0000);
    test_mode <= 1'b1;
    rd(TXP, 32'(bq[1] >> 1));
    test_mode <= 1'b0;
    send(UEPRX_TOK_IN, 4'h3, 0);
    n = 0;
    while ((bq.size() + hsq.size() + rdq.size()) != 0 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n == 500) cmp("pending results", 0, 1);
    cmp("setup taken", 1, takes);
    cmp("setup dropped", 1, drops);
    finish_test();
  end
endmodule
`default_nettype wire
